// ==== design/sep_pkg.sv ====
// Constants and carrier types for the serial EEPROM command port.
// Assumes one 20 MHz system clock and pins sampled through synchronisers.
// ---------------------------------------------------------------
// How it works
// [R1] Word erase sets every bit of the addressed word to one.
// [R2] Select falling after the last address bit starts the self-timed cycle.
// [R3] Select high after a low gap shows busy as low, ready as high.
// [R4] Erase-all sets the whole array to ones, started like a word erase.
// [R5] A started cycle completes with no further serial clocks.
// [R6] Programming is disabled after reset until the enable command.
// [R7] Programming stays enabled until the disable command runs.
// [R8] Master should issue the disable command after programming.
// [R9] Reads run whether programming is enabled or not.
// [R10] Read sends one dummy zero, then the 8 or 16 bit word.
// [R11] Select held high continues reading the next locations.
// [R12] Word write takes 8 or 16 data bits; select falling starts programming.
// [R13] Write-all puts the data word into every location.
// [R14] Write-all erases first itself but still needs programming enabled.
// [R15] Select low during a cycle finishes it, then standby.
// [R16] Select low holds control logic in reset; at least 250 ns between commands.
// [R17] Input bits sampled and output bits changed on serial clock rise.
// [R18] Serial clock may stop at either level without losing state.
// [R19] Clocks before a start bit are ignored.
// [R20] After the needed clock count the command runs; rest ignored until start.
// [R21] Select low through a whole cycle keeps output floating; later status high.
// [R22] Organisation input high means 16-bit words, low means 8-bit.
// [R23] Start bit is the first serial clock rise with select and data high.
// [R24] Opcodes: 11 erase, 10 read, 01 write; 00 uses top address bits.
// [R25] Output floats except for read data or status; floats on select falling.
// [R26] Address is 6 bits in x16, 7 in x8; programming ignored when disabled.
// ---------------------------------------------------------------
package sep_pkg;
  localparam int ADDR_W16 = 6;
  localparam int ADDR_W8 = 7;
  localparam int DATA_W16 = 16;
  localparam int DATA_W8 = 8;
  localparam int OP_W = 2;
  localparam int CNT_W = 5;
  // Opcodes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Extended codes in the top two address bits
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int WORD_CYCLE_US = 4000;
  localparam int ALL_CYCLE_US = 8000;
  localparam int WORD_CYCLE_CLKS = CLK_HZ / 1000000 * WORD_CYCLE_US;
  localparam int ALL_CYCLE_CLKS = CLK_HZ / 1000000 * ALL_CYCLE_US;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  typedef enum logic [2:0] {
    SEP_IDLE = 3'h0,
    SEP_OPC = 3'h1,
    SEP_ADDR = 3'h2,
    SEP_DATA = 3'h3,
    SEP_READ = 3'h4,
    SEP_ARMED = 3'h5,
    SEP_DONE = 3'h6
  } sep_state_e;

  typedef enum logic [1:0] {
    SEP_JOB_NONE = 2'h0,
    SEP_JOB_WORD = 2'h1,
    SEP_JOB_ALL = 2'h2
  } sep_job_e;

  // Programming request handed to the self-timed engine
  typedef struct packed {
    sep_job_e job;
    logic [6:0] addr;
    logic [15:0] data;
  } sep_prog_s;
endpackage : sep_pkg

// ==== design/sep_port.sv ====
// Serial EEPROM command port with memory array and self-timed programming.
// Assumes select, serial clock, data and organisation arrive asynchronously.
`timescale 1ns/1ns
module sep_port #(
  parameter int WORD_CLKS = sep_pkg::WORD_CYCLE_CLKS,
  parameter int ALL_CLKS = sep_pkg::ALL_CYCLE_CLKS,
  parameter int DEPTH = 128
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic org_x16,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      meta_q <= {org_x16, serial_in, serial_clk, chip_select};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
      cs_prev_q <= sync_q[0];
    end
  end
  wire cs = sync_q[0];
  wire din = sync_q[2];
  wire x16 = sync_q[3]; // [R22]
  // Edges found on the system clock, so a stopped serial clock simply holds state
  wire sck_rise = cs & sync_q[1] & ~sck_prev_q; // [R17] [R18]
  wire cs_fall = cs_prev_q & ~cs;
  wire cs_rise = ~cs_prev_q & cs;

  // ---------------------------------------------------------------
  // Memory and self-timed engine
  // ---------------------------------------------------------------
  logic [15:0] mem [DEPTH];
  logic [31:0] timer_q;
  sep_pkg::sep_job_e run_q;
  logic [6:0] run_addr_q;
  logic [15:0] run_data_q;
  logic [7:0] sweep_q;
  logic we_q;
  sep_pkg::sep_prog_s req;
  logic req_valid;
  wire engine_ready = (run_q == sep_pkg::SEP_JOB_NONE);
  assign busy = ~engine_ready;
  // Word location of a byte address: x8 uses halves of the 16-bit cells
  wire [5:0] run_cell = x16 ? run_addr_q[5:0] : run_addr_q[6:1];
  wire [15:0] cell_old = mem[run_cell];
  wire [15:0] word_new = x16 ? run_data_q
    : (run_addr_q[0] ? {run_data_q[7:0], cell_old[7:0]} : {cell_old[15:8], run_data_q[7:0]});
  wire [15:0] all_new = x16 ? run_data_q : {run_data_q[7:0], run_data_q[7:0]};
  // A whole-array job never ends before its sweep has reached each of the DEPTH / 2 cells in use [R4]
  wire sweep_busy = (run_q == sep_pkg::SEP_JOB_ALL) && (sweep_q < 8'(DEPTH / 2));
  wire timer_out = (timer_q <= 32'h1);

  // Engine ignores chip select entirely once started [R5] [R15]
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= sep_pkg::SEP_JOB_NONE;
      timer_q <= 32'h0;
      run_addr_q <= 7'h0;
      run_data_q <= 16'h0;
      sweep_q <= 8'h0;
    end else if (engine_ready && req_valid) begin
      run_q <= req.job;
      run_addr_q <= req.addr;
      run_data_q <= req.data;
      sweep_q <= 8'h0;
      timer_q <= (req.job == sep_pkg::SEP_JOB_ALL) ? 32'(ALL_CLKS) : 32'(WORD_CLKS);
    end else if (!engine_ready) begin
      if (sweep_busy) begin
        sweep_q <= sweep_q + 8'h1;
      end
      if (!timer_out) begin
        timer_q <= timer_q - 32'h1;
      end else if (!sweep_busy) begin
        run_q <= sep_pkg::SEP_JOB_NONE;
      end
    end
  end

  // Array update: one word on the last cycle, or one cell per cycle for whole-array jobs
  always_ff @(posedge clock) begin
    if (run_q == sep_pkg::SEP_JOB_WORD && timer_q == 32'h1) begin
      mem[run_cell] <= word_new; // [R1] [R12]
    end else if (sweep_busy) begin
      mem[sweep_q[5:0]] <= all_new; // [R4] [R13] [R14]
    end
  end

  // ---------------------------------------------------------------
  // Command shifter, held in reset while select is low
  // ---------------------------------------------------------------
  sep_pkg::sep_state_e st_q;
  logic [sep_pkg::CNT_W-1:0] cnt_q;
  logic [1:0] op_q;
  logic [6:0] addr_q;
  logic [15:0] sh_q;
  logic status_q;
  wire [4:0] addr_len = x16 ? 5'(sep_pkg::ADDR_W16) : 5'(sep_pkg::ADDR_W8); // [R26]
  wire [4:0] data_len = x16 ? 5'(sep_pkg::DATA_W16) : 5'(sep_pkg::DATA_W8); // [R10]
  wire [1:0] ext = x16 ? addr_q[5:4] : addr_q[6:5]; // [R24]
  wire [6:0] addr_next = {addr_q[5:0], din};
  wire [6:0] addr_inc = x16 ? {1'b0, 6'(addr_q[5:0] + 6'h1)} : 7'(addr_q + 7'h1);
  wire [5:0] rd_cell = x16 ? addr_q[5:0] : addr_q[6:1];
  wire [15:0] rd_word = x16 ? mem[rd_cell] : (addr_q[0] ? {mem[rd_cell][15:8], 8'h0}
    : {mem[rd_cell][7:0], 8'h0});
  // Extended codes count only under the extended opcode, not in a plain address
  wire is_wr = (op_q == sep_pkg::OP_WRITE)
    || (op_q == sep_pkg::OP_EXT && ext == sep_pkg::EXT_WRITE_ALL);
  wire is_er = (op_q == sep_pkg::OP_ERASE)
    || (op_q == sep_pkg::OP_EXT && ext == sep_pkg::EXT_ERASE_ALL);

  // ---------------------------------------------------------------
  // Ready report after a finished cycle
  // ---------------------------------------------------------------
  // Ready stays reportable after a cycle until the next start bit [R21]
  logic done_q;
  wire start_seen = (st_q == sep_pkg::SEP_IDLE) && sck_rise && din;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else if (engine_ready && req_valid) begin
      done_q <= 1'b1;
    end else if (start_seen) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      we_q <= 1'b0; // [R6]
    end else if (st_q == sep_pkg::SEP_ADDR && sck_rise && cnt_q == 5'h1
        && op_q == sep_pkg::OP_EXT) begin
      if ({addr_next[5:4]} == sep_pkg::EXT_ENABLE && x16
          || addr_next[6:5] == sep_pkg::EXT_ENABLE && !x16) begin
        we_q <= 1'b1; // [R7]
      end else if ({addr_next[5:4]} == sep_pkg::EXT_DISABLE && x16
          || addr_next[6:5] == sep_pkg::EXT_DISABLE && !x16) begin
        we_q <= 1'b0; // [R7]
      end
    end
  end

  // Armed request fires on select falling [R2] [R12]
  assign req_valid = cs_fall && st_q == sep_pkg::SEP_ARMED;
  always_comb begin
    req.job = (op_q == sep_pkg::OP_EXT) ? sep_pkg::SEP_JOB_ALL : sep_pkg::SEP_JOB_WORD;
    req.addr = addr_q;
    req.data = is_er ? sep_pkg::ERASED_WORD : sh_q; // [R1] [R4]
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= sep_pkg::SEP_IDLE;
      cnt_q <= '0;
      op_q <= 2'h0;
      addr_q <= 7'h0;
      sh_q <= 16'h0;
      status_q <= 1'b0;
    end else if (!cs) begin
      // Select low resets control; an armed job keeps its fields until taken
      status_q <= 1'b0; // [R16] [R25]
      if (st_q != sep_pkg::SEP_ARMED || cs_prev_q == 1'b0) begin
        st_q <= sep_pkg::SEP_IDLE;
      end
    end else begin
      if (cs_rise) begin
        status_q <= busy || done_q; // [R3] [R21]
      end
      case (st_q)
        sep_pkg::SEP_IDLE: begin
          if (sck_rise && din) begin
            status_q <= 1'b0; // [R23] [R19]
            st_q <= sep_pkg::SEP_OPC;
            cnt_q <= 5'(sep_pkg::OP_W);
          end
        end
        sep_pkg::SEP_OPC: begin
          if (sck_rise) begin
            op_q <= {op_q[0], din};
            cnt_q <= cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
              st_q <= sep_pkg::SEP_ADDR;
              cnt_q <= addr_len;
            end
          end
        end
        sep_pkg::SEP_ADDR: begin
          if (sck_rise) begin
            addr_q <= addr_next;
            cnt_q <= cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
              cnt_q <= data_len;
              if (op_q == sep_pkg::OP_READ) begin
                st_q <= sep_pkg::SEP_READ; // [R9]
                sh_q <= 16'h0; // [R10]
              end else if (op_q == sep_pkg::OP_ERASE || (op_q == sep_pkg::OP_EXT
                  && (x16 ? addr_next[5:4] : addr_next[6:5]) == sep_pkg::EXT_ERASE_ALL)) begin
                st_q <= (we_q && engine_ready) ? sep_pkg::SEP_ARMED : sep_pkg::SEP_DONE;
              end else if (op_q == sep_pkg::OP_WRITE || (op_q == sep_pkg::OP_EXT
                  && (x16 ? addr_next[5:4] : addr_next[6:5]) == sep_pkg::EXT_WRITE_ALL)) begin
                st_q <= sep_pkg::SEP_DATA;
              end else begin
                st_q <= sep_pkg::SEP_DONE; // [R20]
              end
            end
          end
        end
        sep_pkg::SEP_DATA: begin
          if (sck_rise) begin
            sh_q <= {sh_q[14:0], din};
            cnt_q <= cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
              st_q <= (we_q && engine_ready) ? sep_pkg::SEP_ARMED : sep_pkg::SEP_DONE; // [R26]
            end
          end
        end
        sep_pkg::SEP_READ: begin
          if (sck_rise) begin
            // First rise of each word loads it; the dummy zero shows only before the first word [R10] [R17]
            if (cnt_q == data_len) begin
              sh_q <= rd_word;
            end else begin
              sh_q <= {sh_q[14:0], 1'b0};
            end
            cnt_q <= cnt_q - 5'h1;
            if (cnt_q == 5'h1) begin
              cnt_q <= data_len; // [R11]
              addr_q <= addr_inc;
            end
          end
        end
        sep_pkg::SEP_DONE, sep_pkg::SEP_ARMED: begin
          if (is_wr && is_er) begin
            st_q <= st_q;
          end
        end
        default: st_q <= sep_pkg::SEP_IDLE;
      endcase
    end
  end
  // Next word loads on its own first rise, so sequential reads carry no dummy bit
  logic rd_bit;
  assign rd_bit = sh_q[15];

  // ---------------------------------------------------------------
  // Output pin: driven during read or status, floats otherwise
  // ---------------------------------------------------------------
  logic out_q;
  logic oe_n_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (!cs) begin
      oe_n_q <= 1'b1; // [R25]
    end else if (st_q == sep_pkg::SEP_READ) begin
      oe_n_q <= 1'b0;
      out_q <= rd_bit; // [R10] [R11]
    end else if (status_q) begin
      oe_n_q <= 1'b0;
      out_q <= engine_ready; // [R3]
    end else begin
      oe_n_q <= 1'b1;
    end
  end
  assign serial_out = out_q;
  assign serial_out_oe_n = oe_n_q;
endmodule : sep_port

// ==== verif/sep_port_monitor.sv ====
// Concurrent checks on the serial EEPROM command port pins.
// Assumes the 20 MHz port clock and its active-high async reset.
`timescale 1ns/1ns
module sep_port_monitor #(
  parameter int WORD_CLKS = 50,
  parameter int ALL_CLKS = 80
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic org_x16,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic busy
);
  // ----
  // Busy run length
  // ----
  int unsigned run_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 0;
    end else begin
      run_q <= busy ? run_q + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----
  // Properties
  // ----
  a_float_deselect: assert property (!chip_select [*5] |-> serial_out_oe_n)
    else $error("output driven while deselected");
  a_start_deselect: assert property ($rose(busy) |-> !$past(chip_select))
    else $error("cycle began with select high");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("cycle cut short");
  // Tolerance of a few clocks covers the synchroniser delay
  a_busy_length: assert property ($fell(busy) |->
    run_q >= WORD_CLKS - 2 && run_q <= ALL_CLKS + 4)
    else $error("cycle length off");
  a_status_busy: assert property ((chip_select && busy) [*6] |->
    !serial_out_oe_n && !serial_out)
    else $error("busy not shown low");
  a_ready_after: assert property (chip_select [*6] ##0 $fell(busy) |->
    ##[1:4] (serial_out && !serial_out_oe_n))
    else $error("ready not shown high");
  a_quiet_busy: assert property ((!chip_select && busy) [*4] |-> serial_out_oe_n)
    else $error("output driven in silent cycle");
  a_out_steady: assert property (
    (chip_select && !serial_clk && !busy && !serial_out_oe_n) [*8] |-> $stable(serial_out))
    else $error("output moved off the clock rise");
endmodule : sep_port_monitor

bind sep_port sep_port_monitor #(.WORD_CLKS(WORD_CLKS), .ALL_CLKS(ALL_CLKS)) u_monitor (
  .clock(clock), .sys_rst(sys_rst), .chip_select(chip_select), .serial_clk(serial_clk),
  .serial_in(serial_in), .org_x16(org_x16), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .busy(busy));

// ==== verif/sep_host_model.sv ====
// Serial master model driving select, serial clock and data into the port.
// Assumes the bench calls its tasks; pins move on the system clock's falling edge.
`timescale 1ns/1ns
module sep_host_model (
  input wire logic clock,
  output logic chip_select,
  output logic serial_clk,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // Half period of 200 ns gives a 400 ns link clock, middle bit held high 800 ns; output settles 4 clocks after a rise
  localparam int PHASE = 4;
  initial begin
    chip_select = 1'b0;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // ----
  // Transfers
  // ----
  task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] got);
    got = '0;
    @(negedge clock);
    chip_select = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin // exact count, MSB first
      serial_in = bits[i];
      repeat (PHASE) @(negedge clock);
      serial_clk = 1'b1;
      repeat (i == n / 2 ? 4 * PHASE : PHASE) @(negedge clock);
      got = {got[62:0], serial_out};
      serial_clk = 1'b0;
    end
    serial_in = ~serial_in;
  endtask : frame
  task automatic deselect();
    @(negedge clock);
    chip_select = 1'b0;
    repeat (2 * PHASE) @(negedge clock); // gap above 250 ns
  endtask : deselect
  task automatic status(input int limit, output logic saw_busy, output logic ready);
    @(negedge clock);
    chip_select = 1'b1;
    repeat (8) @(negedge clock);
    saw_busy = (serial_out_oe_n === 1'b0) && (serial_out === 1'b0);
    for (int i = 0; i < limit && serial_out !== 1'b1; i++) @(negedge clock);
    ready = (serial_out_oe_n === 1'b0) && (serial_out === 1'b1);
    deselect();
  endtask : status
endmodule : sep_host_model

// ==== verif/three_wire_eeprom_command_port_bench.sv ====
// Self-checking bench for the serial EEPROM command port.
// Assumes the master model in sep_host_model and short cycle times.
`timescale 1ns/1ns
module three_wire_eeprom_command_port_bench;
  localparam int WORD_CLKS = 50;
  localparam int ALL_CLKS = 80;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic org_x16 = 1'b1;
  logic chip_select, serial_clk, serial_in, serial_out, serial_out_oe_n, busy;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [63:0] got_v;
  logic busy_v, ready_v, float_v;
  always #25 clock = ~clock;
  sep_port #(.WORD_CLKS(WORD_CLKS), .ALL_CLKS(ALL_CLKS)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .chip_select(chip_select), .serial_clk(serial_clk), .serial_in(serial_in), .org_x16(org_x16),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .busy(busy));
  sep_host_model u_host (.clock(clock), .chip_select(chip_select), .serial_clk(serial_clk),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic run(input logic [63:0] bits, input int n);
    u_host.frame(bits, n, got_v);
    u_host.deselect();
  endtask : run
  task automatic prog(input string what, input logic [63:0] bits, input int n, input logic act);
    run(bits, n);
    u_host.status(ALL_CLKS + 20, busy_v, ready_v);
    check({what, " busy"}, 64'(act), 64'(busy_v));
    if (act) check({what, " ready"}, 64'h1, 64'(ready_v));
  endtask : prog
  // Dummy zero is the sample taken on the last address bit's clock
  task automatic rd(input string what, input logic [63:0] cmd, input int cn, input int w,
    input logic [63:0] exp);
    u_host.frame(cmd << w, cn + w, got_v);
    u_host.deselect();
    check(what, exp, got_v & ((64'h1 << (w + 1)) - 64'h1));
  endtask : rd
  // ----
  // Scenarios
  // ----
  task automatic t_erase_all();
    run(64'h130, 9);
    prog("erase all", 64'h120, 9, 1'b1);
    rd("erased pair", 64'h1be, 9, 32, 64'h0ffffffff);
    $display("test erase_all done");
  endtask : t_erase_all
  task automatic t_write();
    prog("write", 64'h146a5c3, 28, 1'b1);
    run(64'h1470f0f, 25);
    float_v = 1'b1;
    busy_v = 1'b0;
    repeat (ALL_CLKS + 20) begin
      @(negedge clock);
      if (serial_out_oe_n !== 1'b1) float_v = 1'b0;
      if (busy === 1'b1) busy_v = 1'b1;
    end
    check("floating", 64'h1, 64'(float_v));
    check("silent cycle", 64'h1, 64'(busy_v));
    u_host.status(4, busy_v, ready_v);
    check("late status", 64'h1, 64'(ready_v));
    rd("pair", 64'h186, 9, 32, 64'h0a5c30f0f);
    prog("erase", 64'h1c6, 9, 1'b1);
    rd("erased", 64'h186, 9, 16, 64'h0ffff);
    $display("test write done");
  endtask : t_write
  task automatic t_locked();
    run(64'h100, 9);
    prog("locked write", 64'h1470000, 25, 1'b0);
    rd("locked", 64'h187, 9, 16, 64'h00f0f);
    $display("test locked done");
  endtask : t_locked
  task automatic t_byte();
    org_x16 = 1'b0;
    run(64'h260, 10);
    prog("fill", 64'h2203c, 18, 1'b1);
    rd("byte", 64'h341, 10, 8, 64'h03c);
    run(64'h200, 10);
    org_x16 = 1'b1;
    $display("test byte done");
  endtask : t_byte
  // ----
  // Run control
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    repeat (5) @(negedge clock);
    t_erase_all();
    t_write();
    t_locked();
    t_byte();
    summarize();
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
endmodule : three_wire_eeprom_command_port_bench
